// >>> inc/clk_tree_pkg.sv
package clk_tree_pkg;

  localparam int unsigned SYS_CLK_MHZ = 100;
  // Emulated pin rates are the true rates divided by this figure
  localparam int unsigned FREQ_SCALE  = 64;
  localparam int unsigned OSC_MIN_MHZ = 100;
  localparam int unsigned OSC_MAX_MHZ = 266;

  localparam int CODE_W      = 3;
  localparam int PER_W       = 16;
  localparam int STEP_W      = 9;
  localparam int NUM_GLOBAL  = 4;
  localparam int PHASE_STEPS = 8;

  localparam int CFG_MULT_LSB  = 0;
  localparam int CFG_DIV_LSB   = 4;
  localparam int CFG_PHASE_LSB = 8;
  localparam int CFG_FB_BIT    = 12;
  localparam int CFG_SEL_LSB   = 16;
  localparam int CMD_APPLY_BIT = 0;
  localparam int ST_RUN_BIT    = 0;
  localparam int ST_REJECT_BIT = 1;
  localparam int ST_LOCK_BIT   = 2;
  localparam int ST_TRACK_BIT  = 3;

  localparam logic [7:0]  ADDR_CFG    = 8'h00;
  localparam logic [7:0]  ADDR_CMD    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_ACTIVE = 8'h0C;
  localparam logic [7:0]  ADDR_PERIOD = 8'h10;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [CODE_W-1:0] CODE_DIV16 = 3'h7;

  // Codes 0..7 map to 1, 2, 3, 4, 5, 6, 8, 16 for both multiply and divide
  function automatic logic [4:0] factor_val(input logic [CODE_W-1:0] code);
    case (code)
      3'h6:    factor_val = 5'h08;
      3'h7:    factor_val = 5'h10;
      default: factor_val = 5'(code) + 5'h01;
    endcase
  endfunction

  function automatic logic spread_ok(input logic [CODE_W-1:0] code);
    spread_ok = (code == 3'h0) || (code == 3'h1) || (code == 3'h3);
  endfunction

endpackage

// >>> inc/reg_if.sv
`timescale 1ns/1ps
interface reg_if;
  logic [31:0] cfg;
  logic        apply;
  logic [31:0] status;
  logic [31:0] active;
  logic [15:0] period;
  modport slave (output cfg, output apply, input status, input active, input period);
  modport core  (input cfg, input apply, output status, output active, output period);
endinterface // reg_if

// >>> design/axi_reg_slave.sv
`timescale 1ns/1ps
module axi_reg_slave import clk_tree_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  reg_if.slave             rif
);
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d;
  logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d, apply_q, apply_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, cfg_q, cfg_d, rdata_q, rdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        aw_have, w_have, do_wr, do_rd;
  logic [7:0]  wa;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    aw_have   = aw_full_q | (awvalid_in & awready_q);
    w_have    = w_full_q | (wvalid_in & wready_q);
    do_wr     = aw_have & w_have & ~bvalid_q;
    awaddr_d  = (awvalid_in & awready_q) ? awaddr_in : awaddr_q;
    wdata_d   = (wvalid_in & wready_q) ? wdata_in : wdata_q;
    wstrb_d   = (wvalid_in & wready_q) ? wstrb_in : wstrb_q;
    wa        = awaddr_d;
    aw_full_d = aw_have & ~do_wr;
    w_full_d  = w_have & ~do_wr;
    awready_d = ~aw_full_d;
    wready_d  = ~w_full_d;
    bvalid_d  = do_wr | (bvalid_q & ~bready_in);
    bresp_d   = bresp_q;
    cfg_d     = cfg_q;
    apply_d   = 1'b0;
    if (do_wr) begin
      bresp_d = RESP_OKAY;
      if (wa == ADDR_CFG) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_d[b]) begin
            cfg_d[b*8 +: 8] = wdata_d[b*8 +: 8];
          end
        end
      end else if (wa == ADDR_CMD) begin
        apply_d = wstrb_d[0] & wdata_d[CMD_APPLY_BIT];
      end else if (wa != ADDR_STATUS && wa != ADDR_ACTIVE && wa != ADDR_PERIOD) begin
        bresp_d = RESP_SLVERR;
      end
    end
    do_rd     = arvalid_in & arready_q;
    rvalid_d  = do_rd | (rvalid_q & ~rready_in);
    arready_d = ~rvalid_d;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (do_rd) begin
      rresp_d = RESP_OKAY;
      case (araddr_in)
        ADDR_CFG:    rdata_d = cfg_q;
        ADDR_CMD:    rdata_d = 32'h0000_0000;
        ADDR_STATUS: rdata_d = rif.status;
        ADDR_ACTIVE: rdata_d = rif.active;
        ADDR_PERIOD: rdata_d = {16'h0000, rif.period};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      apply_q   <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      cfg_q     <= CFG_RESET;
      rdata_q   <= 32'h0000_0000;
      bresp_q   <= RESP_OKAY;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      apply_q   <= apply_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      cfg_q     <= cfg_d;
      rdata_q   <= rdata_d;
      bresp_q   <= bresp_d;
      rresp_q   <= rresp_d;
    end
  end

  assign awready_out = awready_q;
  assign wready_out  = wready_q;
  assign bvalid_out  = bvalid_q;
  assign bresp_out   = bresp_q;
  assign arready_out = arready_q;
  assign rvalid_out  = rvalid_q;
  assign rdata_out   = rdata_q;
  assign rresp_out   = rresp_q;
  assign rif.cfg     = cfg_q;
  assign rif.apply   = apply_q;

endmodule // axi_reg_slave

// >>> design/pll_global_clock_tree.sv
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module pll_global_clock_tree import clk_tree_pkg::*; (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic [7:0]  AXI_AWADDR_IN,
  input  wire logic        AXI_AWVALID_IN,
  output logic             AXI_AWREADY_OUT,
  input  wire logic [31:0] AXI_WDATA_IN,
  input  wire logic [3:0]  AXI_WSTRB_IN,
  input  wire logic        AXI_WVALID_IN,
  output logic             AXI_WREADY_OUT,
  output logic [1:0]       AXI_BRESP_OUT,
  output logic             AXI_BVALID_OUT,
  input  wire logic        AXI_BREADY_IN,
  input  wire logic [7:0]  AXI_ARADDR_IN,
  input  wire logic        AXI_ARVALID_IN,
  output logic             AXI_ARREADY_OUT,
  output logic [31:0]      AXI_RDATA_OUT,
  output logic [1:0]       AXI_RRESP_OUT,
  output logic             AXI_RVALID_OUT,
  input  wire logic        AXI_RREADY_IN,
  input  wire logic        PLL_REFERENCE_CLOCK_PIN_IN,
  input  wire logic        PLL_FEEDBACK_CLOCK_PIN_IN,
  input  wire logic        TRANSMIT_WORD_CLOCK_IN,
  input  wire logic        RECEIVE_WORD_CLOCK_IN,
  output logic [3:0]       INTERNAL_GLOBAL_CLOCK_OUT,
  output logic             OFFCHIP_CLOCK_OUT
);
  reg_if rif();

  axi_reg_slave u_regs (
    .clk_in      (SYS_CLK_IN),
    .nrst_in     (NRST_IN),
    .awaddr_in   (AXI_AWADDR_IN),
    .awvalid_in  (AXI_AWVALID_IN),
    .awready_out (AXI_AWREADY_OUT),
    .wdata_in    (AXI_WDATA_IN),
    .wstrb_in    (AXI_WSTRB_IN),
    .wvalid_in   (AXI_WVALID_IN),
    .wready_out  (AXI_WREADY_OUT),
    .bresp_out   (AXI_BRESP_OUT),
    .bvalid_out  (AXI_BVALID_OUT),
    .bready_in   (AXI_BREADY_IN),
    .araddr_in   (AXI_ARADDR_IN),
    .arvalid_in  (AXI_ARVALID_IN),
    .arready_out (AXI_ARREADY_OUT),
    .rdata_out   (AXI_RDATA_OUT),
    .rresp_out   (AXI_RRESP_OUT),
    .rvalid_out  (AXI_RVALID_OUT),
    .rready_in   (AXI_RREADY_IN),
    .rif         (rif.slave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; bit order is reference, feedback, transmit, receive
  logic [NUM_GLOBAL-1:0] meta_q, sync_q, dly_q;

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      meta_q <= '0;
      sync_q <= '0;
      dly_q  <= '0;
    end else begin
      meta_q <= {RECEIVE_WORD_CLOCK_IN, TRANSMIT_WORD_CLOCK_IN, PLL_FEEDBACK_CLOCK_PIN_IN,
                 PLL_REFERENCE_CLOCK_PIN_IN};
      sync_q <= meta_q;
      dly_q  <= sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [PER_W-1:0]  per_cnt_q, per_cnt_d, per_q, per_d, acc_q, acc_d;
  logic [31:0]       act_q, act_d;
  logic [STEP_W-1:0] step_q, step_d, lim, half, ph, pos;
  logic [PER_W:0]    sum;
  logic [7:0]        inc;
  logic [4:0]        mult, div, cmult;
  logic [31:0]       osc_prod;
  logic [NUM_GLOBAL-1:0] glob_q, glob_d;
  logic run_q, run_d, rej_q, rej_d, lock_q, lock_d, seen_q, seen_d;
  logic track_q, track_d, pend_q, pend_d, adv_q, adv_d, pll_q, pll_d, off_q, off_d, load_q;
  logic ref_rise, fb_rise, tick, fb_mode, cfg_ok, load;
  logic [CODE_W-1:0] c_mult, c_div, c_phase;

  always_comb begin
    ref_rise = sync_q[0] & ~dly_q[0];
    fb_rise  = sync_q[1] & ~dly_q[1];
    // Period measured in system cycles; saturates when the pin stops
    per_cnt_d = ref_rise ? PER_W'(1) : ((&per_cnt_q) ? per_cnt_q : per_cnt_q + PER_W'(1));
    seen_d    = seen_q | ref_rise;
    lock_d    = lock_q | (ref_rise & seen_q);
    // Once running, the period only follows the pin where tracking is allowed
    per_d     = (ref_rise & seen_q & (~run_q | track_q)) ? per_cnt_q : per_q;
    // Candidate setting check against the oscillator window
    c_mult   = rif.cfg[CFG_MULT_LSB +: CODE_W];
    c_div    = rif.cfg[CFG_DIV_LSB +: CODE_W];
    c_phase  = rif.cfg[CFG_PHASE_LSB +: CODE_W];
    cmult    = factor_val(c_mult);
    osc_prod = SYS_CLK_MHZ * FREQ_SCALE * 32'(cmult);
    cfg_ok   = lock_q && (osc_prod >= OSC_MIN_MHZ * 32'(per_q))
               && (osc_prod <= OSC_MAX_MHZ * 32'(per_q));
    if (rif.cfg[CFG_FB_BIT]) begin
      cfg_ok = cfg_ok && (c_mult == 3'h0) && (c_div != CODE_DIV16) && (c_phase == 3'h0);
    end
    load     = rif.apply & cfg_ok;
    act_d    = load ? rif.cfg : act_q;
    run_d    = run_q | load;
    rej_d    = rif.apply ? ~cfg_ok : rej_q;
    track_d  = run_d & spread_ok(act_d[CFG_MULT_LSB +: CODE_W]);
    // Oscillator emulated by a rate accumulator: 8 phase ticks per period
    mult     = factor_val(act_q[CFG_MULT_LSB +: CODE_W]);
    div      = factor_val(act_q[CFG_DIV_LSB +: CODE_W]);
    fb_mode  = act_q[CFG_FB_BIT];
    inc      = 8'(mult) << 3;
    sum      = {1'b0, acc_q} + (PER_W+1)'(inc);
    tick     = run_q && (sum >= {1'b0, per_q});
    acc_d    = load ? '0 : (tick ? PER_W'(sum - {1'b0, per_q}) : PER_W'(sum));
    if (!run_q) begin
      acc_d = '0;
    end
    // Deskew: feedback edge later than reference edge pulls the counter ahead
    pend_d = fb_mode & ((pend_q & ~fb_rise) | ref_rise);
    adv_d  = fb_mode & ((adv_q & ~tick) | (fb_rise & pend_q));
    // Single counter drives every divided and shifted output
    lim    = STEP_W'(div) << 3;
    half   = STEP_W'(div) << 2;
    step_d = step_q + STEP_W'(tick) + STEP_W'(tick & adv_q);
    if (step_d >= lim) begin
      step_d = step_d - lim;
    end
    if (load) begin
      step_d = '0;
    end
    ph  = STEP_W'(act_q[CFG_PHASE_LSB +: CODE_W]);
    pos = step_q + lim - ph;
    if (pos >= lim) begin
      pos = pos - lim;
    end
    pll_d = run_q & (pos < half);
    for (int i = 0; i < NUM_GLOBAL; i++) begin
      glob_d[i] = act_q[CFG_SEL_LSB + i] ? pll_q : sync_q[i];
    end
    // Off-chip copy toggles on each rise of global clock 0, half its rate
    off_d = off_q ^ (glob_d[0] & ~glob_q[0]);
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      per_cnt_q <= '0;
      per_q     <= '0;
      acc_q     <= '0;
      act_q     <= CFG_RESET;
      step_q    <= '0;
      glob_q    <= '0;
      run_q     <= 1'b0;
      rej_q     <= 1'b0;
      lock_q    <= 1'b0;
      seen_q    <= 1'b0;
      track_q   <= 1'b0;
      pend_q    <= 1'b0;
      adv_q     <= 1'b0;
      pll_q     <= 1'b0;
      off_q     <= 1'b0;
      load_q    <= 1'b0;
    end else begin
      per_cnt_q <= per_cnt_d;
      per_q     <= per_d;
      acc_q     <= acc_d;
      act_q     <= act_d;
      step_q    <= step_d;
      glob_q    <= glob_d;
      run_q     <= run_d;
      rej_q     <= rej_d;
      lock_q    <= lock_d;
      seen_q    <= seen_d;
      track_q   <= track_d;
      pend_q    <= pend_d;
      adv_q     <= adv_d;
      pll_q     <= pll_d;
      off_q     <= off_d;
      load_q    <= load;
    end
  end

  assign INTERNAL_GLOBAL_CLOCK_OUT = glob_q;
  assign OFFCHIP_CLOCK_OUT         = off_q;
  assign rif.status = {28'h000_0000, track_q, lock_q, rej_q, run_q};
  assign rif.active = act_q;
  assign rif.period = per_q;

  ////////////////////////////////////////////////////////////////////////////
  // Helper: oscillator ticks counted over one whole reference period
  logic [7:0] tick_cnt_q;
  logic       full_q;
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tick_cnt_q <= '0;
      full_q     <= 1'b0;
    end else begin
      tick_cnt_q <= ref_rise ? 8'(tick) : tick_cnt_q + 8'(tick);
      full_q     <= load ? 1'b0 : (full_q | (ref_rise & run_q));
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence steady_s;
    // Two cycles after an apply the output still mixes old and new settings
    run_q && !load_q && !$past(load_q) && $past(run_q) && !fb_mode;
  endsequence
  sequence alt_held_s;
    !act_q[CFG_SEL_LSB + 2] [*4];
  endsequence

  a_alt_transmit: assert property (alt_held_s |->
      INTERNAL_GLOBAL_CLOCK_OUT[2] == $past(TRANSMIT_WORD_CLOCK_IN, 3))
    else $error("transmit word clock not routed to global clock 2");
  a_pll_route: assert property (act_q[CFG_SEL_LSB + 3] && $stable(act_q) |=>
      INTERNAL_GLOBAL_CLOCK_OUT[3] == $past(pll_q))
    else $error("PLL output not routed to global clock 3");
  a_mult_rate: assert property (ref_rise && full_q && run_q && !track_q && !fb_mode
      |-> (tick_cnt_q + 8'(tick) + 8'h01 >= inc) && (tick_cnt_q + 8'(tick) <= inc + 8'h01))
    else $error("oscillator tick count does not match multiply factor");
  a_div_bound: assert property (run_q |-> step_q < lim)
    else $error("phase counter exceeded divide window");
  a_phase_rise: assert property (steady_s ##0 $rose(pll_q) |-> $past(step_q) == ph)
    else $error("PLL output rose away from selected phase step");
  a_duty_fall: assert property (steady_s ##0 $fell(pll_q) |-> ($past(step_q) + lim - ph) % lim == half)
    else $error("PLL output high time not half the divided period");
  a_spread_hold: assert property (run_q && !track_q |=> $stable(per_q))
    else $error("period followed reference without tracking allowed");
  a_offchip_half: assert property ($changed(OFFCHIP_CLOCK_OUT) |-> $rose(INTERNAL_GLOBAL_CLOCK_OUT[0]))
    else $error("off-chip clock toggled without global clock rise");
  a_fb_advance: assert property (fb_mode && fb_rise && pend_q |=> adv_q)
    else $error("late feedback edge did not request an advance");
  a_cfg_static: assert property (!load |=> $stable(act_q))
    else $error("active setting changed without an accepted apply");
  a_phase_step: assert property (steady_s |-> step_q == $past(step_q) || step_q == ($past(step_q) + 1) % lim)
    else $error("phase counter skipped a step");
  a_reject: assert property (rif.apply && !cfg_ok |=> rej_q && $stable(act_q))
    else $error("out-of-range setting was not rejected");

endmodule // pll_global_clock_tree

// >>> tb/board_clk_model.sv
`timescale 1ns/1ps
module board_clk_model (
  input  wire logic [31:0] ref_half_in,
  input  wire logic        offchip_in,
  output logic             ref_out,
  output logic             fb_out,
  output logic             tx_out,
  output logic             rx_out
);
  ////////////////////////////////////////
  // Board oscillators run free; offsets of 3 and 4 ns keep edges off the system clock grid
  initial begin
    ref_out = 1'b0;
    #3;
    forever #(ref_half_in) ref_out = ~ref_out;
  end

  // Trace delay through the externally clocked devices and back
  assign #7 fb_out = offchip_in;

  initial begin
    tx_out = 1'b0;
    rx_out = 1'b0;
    #4;
    fork
      forever #130 tx_out = ~tx_out;
      forever #170 rx_out = ~rx_out;
    join
  end
endmodule // board_clk_model

// >>> tb/tb_pll_global_clock_tree.sv
`timescale 1ns/1ps
module tb_pll_global_clock_tree import clk_tree_pkg::*; ;
  logic        clk;
  logic        nrst      = 1'b0;
  logic        awv       = 1'b0;
  logic        wv        = 1'b0;
  logic        brdy      = 1'b0;
  logic        arv       = 1'b0;
  logic        rrdy      = 1'b0;
  logic [7:0]  awa       = 8'h00;
  logic [7:0]  ara       = 8'h00;
  logic [31:0] wd        = 32'h0000_0000;
  logic        awr, wr, bv, arr, rv, offc, refc, fbc, txc, rxc;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  logic [3:0]  glob;
  int unsigned ref_half  = 320;
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          fac[8]    = '{1, 2, 3, 4, 5, 6, 8, 16};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  pll_global_clock_tree u_dut (
    .SYS_CLK_IN(clk), .NRST_IN(nrst),
    .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
    .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hF), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wr),
    .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(brdy),
    .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
    .AXI_RDATA_OUT(rd), .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rrdy),
    .PLL_REFERENCE_CLOCK_PIN_IN(refc), .PLL_FEEDBACK_CLOCK_PIN_IN(fbc),
    .TRANSMIT_WORD_CLOCK_IN(txc), .RECEIVE_WORD_CLOCK_IN(rxc),
    .INTERNAL_GLOBAL_CLOCK_OUT(glob), .OFFCHIP_CLOCK_OUT(offc)
  );

  board_clk_model u_board (
    .ref_half_in(ref_half), .offchip_in(offc),
    .ref_out(refc), .fb_out(fbc), .tx_out(txc), .rx_out(rxc)
  );

  ////////////////////////////////////////
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_errors++;
    complete_run();
  endtask

  // One transfer; an extra edge at the end keeps ready lines from being set twice in a step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int n;
    awa  <= a;
    ara  <= a;
    wd   <= d;
    awv  <= w;
    wv   <= w;
    brdy <= w;
    arv  <= !w;
    rrdy <= !w;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (arv && arr) arv <= 1'b0;
      if ((brdy && bv) || (rrdy && rv)) break;
    end
    q = rd;
    r = w ? br : rr;
    brdy <= 1'b0;
    rrdy <= 1'b0;
    if (n == 64) hang();
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic [1:0]  r;
    bus(1'b0, a, 32'h0000_0000, q, r);
    chk(q, e);
    chk(32'(r), 32'(RESP_OKAY));
  endtask

  function automatic logic [31:0] mk(input int m, input int d, input int p, input int fb, input int s);
    return (32'(m) << CFG_MULT_LSB) | (32'(d) << CFG_DIV_LSB) | (32'(p) << CFG_PHASE_LSB)
         | (32'(fb) << CFG_FB_BIT) | (32'(s) << CFG_SEL_LSB);
  endfunction

  task automatic apply(input logic [31:0] c, output logic [31:0] st);
    logic [1:0] r;
    bus(1'b1, ADDR_CFG, c, st, r);
    bus(1'b1, ADDR_CMD, 32'(1) << CMD_APPLY_BIT, st, r);
    bus(1'b0, ADDR_STATUS, 32'h0000_0000, st, r);
  endtask

  task automatic wait_per(input int e);
    logic [31:0] q;
    logic [1:0]  r;
    for (int n = 0; n < 60; n++) begin
      bus(1'b0, ADDR_PERIOD, 32'h0000_0000, q, r);
      if (q === 32'(e)) break;
      repeat (20) @(posedge clk);
    end
    chk(q, 32'(e));
    if (q !== 32'(e)) complete_run();
  endtask

  // Period and high time in system cycles, from one rising edge to the next
  task automatic meas(input int i, output int per, output int hi);
    logic v;
    logic p;
    int   st;
    per = 0;
    hi  = 0;
    st  = 0;
    p   = 1'b1;
    for (int n = 0; n < 4000 && st < 2; n++) begin
      @(posedge clk);
      v = (i == 4) ? offc : glob[i];
      if (v && !p) st++;
      if (st == 1) begin
        per++;
        hi += int'(v);
      end
      p = v;
    end
    if (st < 2) hang();
  endtask

  ////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] q;
    logic [1:0]  r;
    rdchk(ADDR_CFG, CFG_RESET);
    rdchk(ADDR_ACTIVE, 32'h0000_0000);
    bus(1'b0, 8'h14, 32'h0000_0000, q, r);
    chk(32'(r), 32'(RESP_SLVERR));
    bus(1'b1, 8'h14, 32'hFFFF_FFFF, q, r);
    chk(32'(r), 32'(RESP_SLVERR));
  endtask

  // After reset every global clock follows its alternate pin; feedback returns the half-rate clock
  task automatic t_alt();
    int ex[4] = '{64, 128, 26, 34};
    int per;
    int hi;
    for (int i = 0; i < 4; i++) begin
      meas(i, per, hi);
      chk(32'(per), 32'(ex[i]));
    end
  endtask

  task automatic t_fb();
    logic [31:0] st;
    logic [31:0] bad[3];
    logic [31:0] good;
    int          per;
    int          hi;
    int          pf;
    good = mk(0, 1, 0, 1, 1);
    bad  = '{mk(0, 1, 2, 1, 1), mk(0, 7, 0, 1, 1), mk(1, 1, 0, 1, 1)};
    wait_per(64);
    apply(good, st);
    chk(32'(st[ST_LOCK_BIT]), 32'h0000_0001);
    chk(32'(st[ST_REJECT_BIT]), 32'h0000_0000);
    // Let the deskew loop settle; the returned clock must then repeat the off-chip period
    meas(1, per, hi);
    meas(1, pf, hi);
    meas(4, per, hi);
    chk(32'(pf), 32'(per));
    for (int i = 0; i < 3; i++) begin
      apply(bad[i], st);
      chk(32'(st[ST_REJECT_BIT]), 32'h0000_0001);
      rdchk(ADDR_ACTIVE, good);
    end
  endtask

  task automatic t_mult();
    logic [31:0] st;
    logic [31:0] c;
    logic [31:0] prev;
    logic        ok;
    int unsigned osc;
    prev     = mk(0, 1, 0, 1, 1);
    ref_half = 400;
    wait_per(80);
    for (int m = 0; m < 8; m++) begin
      c   = mk(m, 1, 0, 0, 15);
      osc = 100 * FREQ_SCALE * fac[m];
      ok  = (osc >= OSC_MIN_MHZ * 80) && (osc <= OSC_MAX_MHZ * 80);
      apply(c, st);
      chk(32'(st[ST_REJECT_BIT]), 32'(!ok));
      if (ok) begin
        prev = c;
        chk(32'(st[ST_TRACK_BIT]), 32'(fac[m] inside {1, 2, 4}));
      end
      rdchk(ADDR_ACTIVE, prev);
    end
  endtask

  // Multiply by 2 on an 80-cycle reference: oscillator period 40 cycles
  task automatic t_div();
    logic [31:0] st;
    int          per;
    int          hi;
    for (int d = 0; d < 8; d++) begin
      apply(mk(1, d, d, 0, 15), st);
      chk(32'(st[ST_REJECT_BIT]), 32'h0000_0000);
      meas(d % 4, per, hi);
      meas(d % 4, per, hi);
      chk(32'(per), 32'(40 * fac[d]));
      chk(32'(2 * hi), 32'(per));
      chk(32'(glob), 32'({4{glob[0]}}));
      meas(4, per, hi);
      chk(32'(per), 32'(80 * fac[d]));
    end
  endtask

  task automatic t_static();
    logic [31:0] q;
    logic [1:0]  r;
    int          per;
    int          hi;
    bus(1'b1, ADDR_CFG, mk(1, 0, 0, 0, 15), q, r);
    rdchk(ADDR_CFG, mk(1, 0, 0, 0, 15));
    rdchk(ADDR_ACTIVE, mk(1, 7, 7, 0, 15));
    meas(0, per, hi);
    chk(32'(per), 32'(640));
  endtask

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_alt();
    t_fb();
    t_mult();
    t_div();
    t_static();
    complete_run();
  end
endmodule // tb_pll_global_clock_tree
